// >>> logic/lfdc_pkg.sv
// Constants for the LF receiver duty-cycle control block.
// Assumes a 100 MHz system clock and a nominal 1 kHz LF oscillator tick.
package lfdc_pkg;

  // Clock and time base
  localparam int unsigned CLK_PERIOD_PS   = 10000;
  localparam int unsigned LFO_PERIOD_MS   = 1;
  localparam int unsigned LFO_DIV_CYCLES  = (LFO_PERIOD_MS * 1000000000) / CLK_PERIOD_PS;
  localparam int unsigned INIT_TIME_MS    = 2;
  localparam logic [12:0] INIT_TICKS      = 13'((INIT_TIME_MS + LFO_PERIOD_MS - 1) / LFO_PERIOD_MS);
  localparam int unsigned RX_TIMEOUT_DEF  = 256;

  // Register offsets
  localparam logic [7:0] OFS_CTL_TWO   = 8'h21;
  localparam logic [7:0] OFS_CTL_THREE = 8'h22;
  localparam logic [7:0] OFS_STATUS    = 8'h23;
  localparam logic [7:0] OFS_MASK      = 8'h24;
  localparam logic [7:0] OFS_MODE      = 8'h25;

  // Field positions in control register three
  localparam int unsigned POS_DET_OUT  = 7;
  localparam int unsigned POS_TOGGLE   = 6;
  localparam int unsigned POS_SYNC     = 4;
  localparam int unsigned POS_CAR_TIME = 0;

  // Reset values
  localparam logic [3:0] RST_INTERVAL_SEL = 4'h6;
  localparam logic [3:0] RST_ON_TIME_SEL  = 4'h0;
  localparam logic       RST_TOGGLE       = 1'b0;
  localparam logic [1:0] RST_SYNC_SEL     = 2'h1;
  localparam logic [3:0] RST_CAR_TIME_SEL = 4'h0;
  localparam logic       RST_CARRIER_MODE = 1'b1;

  // Decode limits
  localparam logic [3:0]  ON_SEL_MAX     = 4'hA;
  localparam logic [3:0]  IVL_SEL_MAX    = 4'h9;
  localparam logic [12:0] IVL_BASE_TICKS = 13'h0010;
  localparam logic [12:0] IVL_MAX_TICKS  = 13'h1000;

  // Status bit positions
  localparam int unsigned EV_CARRIER = 0;
  localparam int unsigned EV_MSG_END = 1;
  localparam int unsigned EV_MSG_ERR = 2;
  localparam int unsigned EV_TIMEOUT = 3;
  localparam int unsigned EV_COUNT   = 4;

  typedef enum logic [2:0] {
    ST_WAIT = 3'b000,
    ST_CONT = 3'b001,
    ST_ON   = 3'b010,
    ST_RX   = 3'b011,
    ST_OFF  = 3'b100,
    ST_INIT = 3'b101
  } lfdc_state_e;

endpackage

// >>> logic/lfdc_tick_if.sv
// Link between the LF tick divider and the duty-cycle controller.
// Both ends run on the system clock.
`timescale 1ns/1ps
interface lfdc_tick_if;
  logic tick;
  logic resync;

  modport gen (output tick, input resync);
  modport use_tick (input tick, output resync);
endinterface

// >>> logic/lfdc_lfo_div.sv
// Divider making the nominal LF oscillator tick as a one-cycle enable.
// Assumes clock_i is the system clock; resync restarts the LF phase.
`timescale 1ns/1ps
module lfdc_lfo_div
  import lfdc_pkg::*;
#(
  parameter int unsigned DIV_CYCLES = LFO_DIV_CYCLES
) (
  input  wire logic  clock_i,
  input  wire logic  arst_n_i,
  lfdc_tick_if.gen   tick_if
);

  typedef struct packed {
    logic [31:0] cnt;
    logic        tick;
  } lfdc_div_s;

  lfdc_div_s div_reg;
  lfdc_div_s div_next;

  always_comb begin
    div_next      = div_reg;
    div_next.tick = 1'b0;
    if (tick_if.resync) begin
      div_next.cnt = 32'h0;
    end else if (div_reg.cnt >= DIV_CYCLES - 1) begin
      div_next.cnt  = 32'h0;
      div_next.tick = 1'b1;
    end else begin
      div_next.cnt = div_reg.cnt + 32'h1;
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_next;
    end
  end

  assign tick_if.tick = div_reg.tick;

endmodule

// >>> logic/lfdc_duty_ctrl.sv
// LF receiver duty-cycle controller: sampling schedule, detector power,
// carrier/data mode handling, control registers and interrupt.
// Assumes a single 100 MHz clock; slicer input is asynchronous, message
// status inputs come from logic on the same clock.
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
module lfdc_duty_ctrl
  import lfdc_pkg::*;
#(
  parameter int unsigned LFO_DIV    = LFO_DIV_CYCLES,
  parameter int unsigned RX_TIMEOUT = RX_TIMEOUT_DEF
) (
  input  wire logic        clock_i,
  input  wire logic        arst_n_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [7:0]  rdata_o,
  input  wire logic        slicer_i,
  input  wire logic        msg_end_i,
  input  wire logic        msg_err_i,
  output logic             detector_en_o,
  output logic             detector_init_o,
  output logic             carrier_mode_o,
  output logic      [1:0]  sync_sel_o,
  output logic             irq_o
);

  typedef struct packed {
    logic [3:0]  sample_interval_sel;
    logic [3:0]  detector_on_time_sel;
    logic        mode_toggle_en;
    logic [1:0]  sync_sel;
    logic [3:0]  min_carrier_time_sel;
    logic        carrier_mode_sel;
    logic [3:0]  status;
    logic [3:0]  mask;
    logic [7:0]  rdata;
    lfdc_state_e state;
    logic [12:0] ivl_cnt;
    logic [4:0]  car_cnt;
    logic [12:0] rx_cnt;
    logic        det_en;
    logic        det_init;
    logic        irq;
  } lfdc_ctrl_s;

  lfdc_ctrl_s  ctrl_reg;
  lfdc_ctrl_s  ctrl_next;
  logic [1:0]  slicer_sync_reg;
  logic        slicer;
  logic        tick;
  lfdc_tick_if tick_if ();

  // ON window length in LF ticks
  function automatic logic [12:0] on_ticks(input logic [3:0] sel);
    logic [3:0] s;
    s = (sel > ON_SEL_MAX) ? ON_SEL_MAX : sel;
    return 13'h0001 << s;
  endfunction

  // Sampling interval in LF ticks, zero means continuous
  function automatic logic [12:0] ivl_ticks(input logic [3:0] sel);
    logic [12:0] t;
    t = 13'h0000;
    if (sel > IVL_SEL_MAX) begin
      t = IVL_MAX_TICKS;
    end else if (sel != 4'h0) begin
      t = IVL_BASE_TICKS << (sel - 4'h1);
    end
    return t;
  endfunction

  lfdc_lfo_div #(
    .DIV_CYCLES (LFO_DIV)
  ) u_lfo_div (
    .clock_i  (clock_i),
    .arst_n_i (arst_n_i),
    .tick_if  (tick_if.gen)
  );

  assign tick = tick_if.tick;

  // Slicer sync has no reset so the read-back bit ignores reset
  always_ff @(posedge clock_i) begin
    slicer_sync_reg <= {slicer_sync_reg[0], slicer_i};
  end

  assign slicer = slicer_sync_reg[1];

  always_comb begin
    logic [12:0]         period;
    logic [12:0]         on_len;
    logic [4:0]          car_min;
    logic [EV_COUNT-1:0] ev;
    logic                seq_end;
    logic                ctl2_wr;

    period  = ivl_ticks(ctrl_reg.sample_interval_sel);
    on_len  = on_ticks(ctrl_reg.detector_on_time_sel);
    car_min = {1'b0, ctrl_reg.min_carrier_time_sel} + 5'h01;
    ev      = '0;
    seq_end = 1'b0;
    ctl2_wr = wr_i && (addr_i == OFS_CTL_TWO);

    ctrl_next       = ctrl_reg;
    ctrl_next.rdata = 8'h00;
    tick_if.resync  = 1'b0;

    // Schedule
    unique case (ctrl_reg.state)
      ST_WAIT: begin
        if (tick) begin
          ctrl_next.ivl_cnt = 13'h0000;
          ctrl_next.car_cnt = 5'h00;
          ctrl_next.state   = (period == 13'h0000) ? ST_CONT : ST_ON;
        end
      end
      ST_CONT: begin
        ctrl_next.state = ST_CONT;
      end
      ST_ON: begin
        if (!ctrl_reg.carrier_mode_sel && slicer) begin
          ctrl_next.state  = ST_RX;
          ctrl_next.rx_cnt = 13'h0000;
        end else if (tick) begin
          ctrl_next.ivl_cnt = ctrl_reg.ivl_cnt + 13'h0001;
          if (ctrl_reg.carrier_mode_sel) begin
            ctrl_next.car_cnt = slicer ? ctrl_reg.car_cnt + 5'h01 : 5'h00;
          end
          if (ctrl_reg.carrier_mode_sel && slicer && (ctrl_reg.car_cnt + 5'h01 >= car_min)) begin
            ev[EV_CARRIER]  = 1'b1;
            seq_end         = 1'b1;
            ctrl_next.state = ST_OFF;
          end else if (ctrl_reg.ivl_cnt + 13'h0001 >= on_len) begin
            seq_end         = 1'b1;
            ctrl_next.state = ST_OFF;
          end
        end
      end
      ST_RX: begin
        if (tick) begin
          ctrl_next.ivl_cnt = (ctrl_reg.ivl_cnt < IVL_MAX_TICKS) ? ctrl_reg.ivl_cnt + 13'h0001 : ctrl_reg.ivl_cnt;
          ctrl_next.rx_cnt  = ctrl_reg.rx_cnt + 13'h0001;
        end
        if (msg_end_i || msg_err_i) begin
          ev[EV_MSG_END]  = msg_end_i;
          ev[EV_MSG_ERR]  = msg_err_i;
          seq_end         = 1'b1;
          ctrl_next.state = ST_OFF;
        end else if (tick && (ctrl_reg.rx_cnt + 13'h0001 >= 13'(RX_TIMEOUT))) begin
          ev[EV_TIMEOUT]  = 1'b1;
          seq_end         = 1'b1;
          ctrl_next.state = ST_OFF;
        end
      end
      ST_OFF, ST_INIT: begin
        if (tick) begin
          ctrl_next.ivl_cnt = ctrl_reg.ivl_cnt + 13'h0001;
          if (ctrl_reg.ivl_cnt + 13'h0001 >= period) begin
            ctrl_next.ivl_cnt = 13'h0000;
            ctrl_next.car_cnt = 5'h00;
            ctrl_next.state   = ST_ON;
          end else if ((period > on_len + INIT_TICKS) &&
                       (ctrl_reg.ivl_cnt + 13'h0001 >= period - INIT_TICKS)) begin
            ctrl_next.state = ST_INIT;
          end
        end
      end
      default: begin
        ctrl_next.state = ST_WAIT;
      end
    endcase

    if (seq_end && ctrl_reg.mode_toggle_en) begin
      ctrl_next.carrier_mode_sel = ~ctrl_reg.carrier_mode_sel;
    end

    // Register writes
    if (wr_i) begin
      unique case (addr_i)
        OFS_CTL_TWO: begin
          ctrl_next.sample_interval_sel  = wdata_i[7:4];
          ctrl_next.detector_on_time_sel = wdata_i[3:0];
        end
        OFS_CTL_THREE: begin
          ctrl_next.mode_toggle_en       = wdata_i[POS_TOGGLE];
          ctrl_next.sync_sel             = wdata_i[POS_SYNC +: 2];
          ctrl_next.min_carrier_time_sel = wdata_i[POS_CAR_TIME +: 4];
        end
        OFS_MASK: begin
          ctrl_next.mask = wdata_i[EV_COUNT-1:0];
        end
        OFS_MODE: begin
          ctrl_next.carrier_mode_sel = wdata_i[0];
        end
        default: begin
          ctrl_next.rdata = 8'h00;
        end
      endcase
    end

    if (ctl2_wr) begin
      ctrl_next.state = ST_WAIT;
    end

    // Sticky events, set wins over clear
    if (wr_i && (addr_i == OFS_STATUS)) begin
      ctrl_next.status = ctrl_reg.status & ~wdata_i[EV_COUNT-1:0];
    end
    ctrl_next.status = ctrl_next.status | ev;

    // Reads
    if (rd_i) begin
      unique case (addr_i)
        OFS_CTL_TWO: begin
          ctrl_next.rdata = {ctrl_reg.sample_interval_sel, ctrl_reg.detector_on_time_sel};
        end
        OFS_CTL_THREE: begin
          ctrl_next.rdata = {slicer, ctrl_reg.mode_toggle_en, ctrl_reg.sync_sel,
                             ctrl_reg.min_carrier_time_sel};
        end
        OFS_STATUS: begin
          ctrl_next.rdata = {4'h0, ctrl_reg.status};
        end
        OFS_MASK: begin
          ctrl_next.rdata = {4'h0, ctrl_reg.mask};
        end
        OFS_MODE: begin
          ctrl_next.rdata = {4'h0, 1'b0, ctrl_reg.state};
          ctrl_next.rdata[POS_DET_OUT] = ctrl_reg.carrier_mode_sel;
        end
        default: begin
          ctrl_next.rdata = 8'h00;
        end
      endcase
    end

    ctrl_next.det_en   = (ctrl_next.state == ST_ON) || (ctrl_next.state == ST_RX) ||
                         (ctrl_next.state == ST_CONT);
    ctrl_next.det_init = (ctrl_next.state == ST_INIT);
    ctrl_next.irq      = |(ctrl_next.status & ctrl_next.mask);
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_reg                      <= '0;
      ctrl_reg.sample_interval_sel  <= RST_INTERVAL_SEL;
      ctrl_reg.detector_on_time_sel <= RST_ON_TIME_SEL;
      ctrl_reg.mode_toggle_en       <= RST_TOGGLE;
      ctrl_reg.sync_sel             <= RST_SYNC_SEL;
      ctrl_reg.min_carrier_time_sel <= RST_CAR_TIME_SEL;
      ctrl_reg.carrier_mode_sel     <= RST_CARRIER_MODE;
      ctrl_reg.state                <= ST_WAIT;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  assign rdata_o         = ctrl_reg.rdata;
  assign detector_en_o   = ctrl_reg.det_en;
  assign detector_init_o = ctrl_reg.det_init;
  assign carrier_mode_o  = ctrl_reg.carrier_mode_sel;
  assign sync_sel_o      = ctrl_reg.sync_sel;
  assign irq_o           = ctrl_reg.irq;

endmodule

// >>> tb/lfdc_duty_ctrl_assertions.sv
// Port checker for the LF duty-cycle controller.
// Assumes single clock, async active-low reset, bound below.
`timescale 1ns/1ps
module lfdc_duty_ctrl_assertions
  import lfdc_pkg::*;
(
  input  wire logic       clock_i,
  input  wire logic       arst_n_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  input  wire logic [7:0] rdata_o,
  input  wire logic       slicer_i,
  input  wire logic       msg_end_i,
  input  wire logic       msg_err_i,
  input  wire logic       detector_en_o,
  input  wire logic       detector_init_o,
  input  wire logic       carrier_mode_o,
  input  wire logic [1:0] sync_sel_o,
  input  wire logic       irq_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);

  chk_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data outside read cycle");
  chk_unmapped_read: assert property (rd_i && addr_i > OFS_MODE |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  chk_sync_follow: assert property (wr_i && addr_i == OFS_CTL_THREE |=> sync_sel_o == $past(wdata_i[5:4]))
    else $error("sync select not taken");
  chk_mode_write: assert property (wr_i && addr_i == OFS_MODE |=> carrier_mode_o == $past(wdata_i[0]))
    else $error("mode write not taken");
  chk_sched_wait: assert property (wr_i && addr_i == OFS_CTL_TWO |=> !detector_en_o)
    else $error("detector on after interval write");
  chk_init_off: assert property (!(detector_en_o && detector_init_o))
    else $error("init overlaps ON time");
  chk_on_min: assert property ($fell(detector_en_o) && !$past(wr_i) |-> $past(detector_en_o, 8))
    else $error("ON window too short");
  chk_irq_masked: assert property (wr_i && addr_i == OFS_MASK && wdata_i == 8'h00 |-> ##2 !irq_o)
    else $error("masked interrupt still high");
  chk_irq_clear: assert property (wr_i && addr_i == OFS_STATUS && wdata_i == 8'h0F && !slicer_i
                                  && !msg_end_i && !msg_err_i |-> ##2 !irq_o)
    else $error("interrupt not cleared");
endmodule

bind lfdc_duty_ctrl lfdc_duty_ctrl_assertions u_chk (.clock_i, .arst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i,
  .rdata_o, .slicer_i, .msg_end_i, .msg_err_i, .detector_en_o, .detector_init_o, .carrier_mode_o,
  .sync_sel_o, .irq_o);

// >>> tb/lfdc_lf_xmit.sv
// Model of the LF transmitter as seen through slicer and decoder.
// Assumes the bench sets field level and the message outcome.
`timescale 1ns/1ps
module lfdc_lf_xmit (
  input  wire logic       clock_i,
  input  wire logic       arst_n_i,
  input  wire logic       carrier_i,
  input  wire logic [1:0] end_kind_i,
  input  wire logic [7:0] end_delay_i,
  input  wire logic       detector_en_i,
  output logic            slicer_o,
  output logic            msg_end_o,
  output logic            msg_err_o
);
  logic [7:0] on_cnt;

  assign slicer_o = carrier_i;

  // Decoder verdict a set delay into the ON window
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      on_cnt    <= 8'h00;
      msg_end_o <= 1'b0;
      msg_err_o <= 1'b0;
    end else begin
      on_cnt    <= detector_en_i ? on_cnt + 8'h01 : 8'h00;
      msg_end_o <= detector_en_i && carrier_i && end_kind_i == 2'h1 && on_cnt == end_delay_i;
      msg_err_o <= detector_en_i && carrier_i && end_kind_i == 2'h2 && on_cnt == end_delay_i;
    end
  end
endmodule

// >>> tb/lfdc_duty_ctrl_tb_top.sv
// Self-checking bench for the LF duty-cycle controller.
// Assumes LF tick of 10 clocks and a receive timeout of 8 ticks.
`timescale 1ns/1ps
module lfdc_duty_ctrl_tb_top;
  import lfdc_pkg::*;
  logic       clock_i = 1'b0;
  logic       arst_n_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic       wr_i = 1'b0;
  logic       rd_i = 1'b0;
  logic       carrier_i = 1'b0;
  logic [1:0] end_kind_i = 2'h0;
  logic [7:0] end_delay_i = 8'h1E;
  logic [7:0] rdata_o;
  logic       slicer_i, msg_end_i, msg_err_i;
  logic       detector_en_o, detector_init_o, carrier_mode_o, irq_o;
  logic [1:0] sync_sel_o;
  int         bad_count = 0;
  int         cmp_count = 0;

  always #5 clock_i = ~clock_i;

  lfdc_duty_ctrl #(.LFO_DIV(10), .RX_TIMEOUT(8)) DUT (.clock_i, .arst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .slicer_i, .msg_end_i, .msg_err_i, .detector_en_o, .detector_init_o, .carrier_mode_o,
    .sync_sel_o, .irq_o);
  lfdc_lf_xmit u_xmit (.clock_i, .arst_n_i, .carrier_i, .end_kind_i, .end_delay_i,
    .detector_en_i(detector_en_o), .slicer_o(slicer_i), .msg_end_o(msg_end_i), .msg_err_o(msg_err_i));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clock_i);
    wr_i    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clock_i);
    rd_i   <= 1'b0;
    #1 d = rdata_o;
  endtask

  // ON length of the next window, then OFF and init length up to the one after
  task automatic meas(input bit full, output int hi, output int lo, output int ini);
    int n;
    n = 0;
    hi = 0;
    lo = 0;
    ini = 0;
    // Let a schedule write that ended on this edge settle first
    #1;
    while (detector_en_o !== 1'b1 && n < 20000) begin cyc(1); n++; end
    while (detector_en_o === 1'b1 && hi < 20000) begin cyc(1); hi++; end
    while (full && detector_en_o !== 1'b1 && lo < 20000) begin
      cyc(1);
      lo++;
      if (detector_init_o === 1'b1) ini++;
    end
  endtask

  task automatic t_regs;
    logic [7:0] d;
    rd(OFS_CTL_TWO, d); chk(16'(d), 16'h0060, "ctl two reset");
    rd(OFS_CTL_THREE, d); chk(16'(d & 8'h7F), 16'h0010, "ctl three reset");
    chk(16'(sync_sel_o), 16'h0001, "sync reset");
    rd(8'h30, d); chk(16'(d), 16'h0000, "unmapped read");
    for (int s = 0; s < 4; s++) begin
      wr(OFS_CTL_THREE, 8'h80 | 8'(s * 17));
      rd(OFS_CTL_THREE, d); chk(16'(d & 8'h7F), 16'(s * 17), "ctl three rw");
      chk(16'(sync_sel_o), 16'(s), "sync select");
    end
    carrier_i <= 1'b1;
    cyc(4);
    rd(OFS_CTL_THREE, d); chk(16'(d[7]), 16'h0001, "detector flag high");
    carrier_i <= 1'b0;
    cyc(4);
    rd(OFS_CTL_THREE, d); chk(16'(d[7]), 16'h0000, "detector flag low");
    wr(OFS_CTL_THREE, 8'h10);
  endtask

  task automatic t_ontime;
    int hi, lo, ini;
    for (int c = 0; c < 4; c++) begin
      wr(OFS_CTL_TWO, 8'h10 | 8'(c));
      meas(c == 3, hi, lo, ini); chk(16'(hi), 16'(10 << c), "ON length");
    end
    chk(16'(lo), 16'd80, "OFF length");
    chk(16'(ini), 16'd20, "init length");
    wr(OFS_CTL_TWO, 8'h9F);
    meas(1'b0, hi, lo, ini); chk(16'(hi), 16'd10240, "longest ON");
    wr(OFS_CTL_TWO, 8'h00);
    cyc(40);
    chk(16'(detector_en_o), 16'h0001, "continuous ON");
    wr(OFS_CTL_TWO, 8'h10);
  endtask

  task automatic t_carrier;
    int hi, lo, ini;
    wr(OFS_CTL_THREE, 8'h1F);
    wr(OFS_MASK, 8'h01);
    wr(OFS_STATUS, 8'h0F);
    wr(OFS_CTL_TWO, 8'h13);
    carrier_i <= 1'b1;
    meas(1'b0, hi, lo, ini); chk(16'(hi), 16'd80, "carrier too short");
    wr(OFS_CTL_THREE, 8'h11);
    wr(OFS_CTL_TWO, 8'h13);
    meas(1'b0, hi, lo, ini); chk(16'(hi >= 20 && hi < 80), 16'h0001, "early off");
    cyc(2);
    chk(16'(irq_o), 16'h0001, "carrier irq");
    carrier_i <= 1'b0;
    cyc(4);
    wr(OFS_STATUS, 8'h0F);
    cyc(3);
    chk(16'(irq_o), 16'h0000, "irq cleared");
    wr(OFS_MASK, 8'h00);
  endtask

  task automatic t_data;
    int hi, lo, ini;
    logic [7:0] d;
    wr(OFS_MODE, 8'h00);
    cyc(1);
    chk(16'(carrier_mode_o), 16'h0000, "data mode");
    wr(OFS_MASK, 8'h0E);
    for (int k = 1; k < 4; k++) begin
      end_kind_i <= 2'(k);
      carrier_i  <= 1'b1;
      wr(OFS_CTL_TWO, 8'h10);
      meas(1'b0, hi, lo, ini);
      if (k < 3) chk(16'(hi >= 30 && hi <= 34), 16'h0001, "held to message end");
      else chk(16'(hi >= 70 && hi <= 100), 16'h0001, "held to timeout");
      carrier_i <= 1'b0;
      cyc(2);
      chk(16'(irq_o), 16'h0001, "data irq");
      rd(OFS_STATUS, d); chk(16'(d & 8'h0E), 16'(1 << k), "data status");
      wr(OFS_STATUS, 8'h0F);
    end
    wr(OFS_MASK, 8'h00);
  endtask

  task automatic t_toggle;
    int hi, lo, ini;
    wr(OFS_MODE, 8'h01);
    wr(OFS_CTL_THREE, 8'h50);
    wr(OFS_CTL_TWO, 8'h10);
    for (int i = 0; i < 2; i++) begin
      meas(1'b0, hi, lo, ini);
      cyc(3);
      chk(16'(carrier_mode_o), 16'(i), "mode toggled");
    end
    wr(OFS_CTL_THREE, 8'h10);
  endtask

  // Reset in mid-run with fields moved off their reset values
  task automatic t_reset;
    logic [7:0] d;
    wr(OFS_CTL_TWO, 8'h3A);
    wr(OFS_CTL_THREE, 8'h6F);
    wr(OFS_MODE, 8'h00);
    carrier_i <= 1'b1;
    cyc(4);
    arst_n_i  <= 1'b0;
    cyc(3);
    arst_n_i  <= 1'b1;
    rd(OFS_CTL_TWO, d); chk(16'(d), 16'h0060, "ctl two after reset");
    rd(OFS_CTL_THREE, d); chk(16'(d), 16'h0090, "ctl three after reset");
    chk(16'(sync_sel_o), 16'h0001, "sync after reset");
    chk(16'(carrier_mode_o), 16'h0001, "mode after reset");
    carrier_i <= 1'b0;
  endtask

  task automatic final_report;
    $display("Comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge clock_i);
    arst_n_i <= 1'b1;
    t_regs(); $display("register test done");
    t_ontime(); $display("ON time test done");
    t_carrier(); $display("carrier test done");
    t_data(); $display("data test done");
    t_toggle(); $display("toggle test done");
    t_reset(); $display("reset test done");
    final_report();
  end

  initial begin
    repeat (40000) @(posedge clock_i);
    bad_count++;
    $display("Error at %0t: watchdog expired", $time);
    final_report();
  end
endmodule
